// ### verilog/spgl_pkg.sv
// Purpose: Shared constants for the sector guard and password lock block.
// Assumes: Command codes are internal to this block, not bus encodings.
// Notes: Times are given in nanoseconds and converted to cycles here.
package spgl_pkg;
   localparam int unsigned SYS_CLK_HZ      = 40_000_000;
   localparam int unsigned PW_WAIT_NS      = 100_000;
   localparam int unsigned PW_WAIT_CYC     = (PW_WAIT_NS / 1000) * (SYS_CLK_HZ / 1_000_000);
   localparam int          PW_BITS         = 64;
   localparam int          SECT_AW         = 4;
   localparam logic [1:0]  MODE_NONE       = 2'h3;
   localparam logic [1:0]  MODE_PERSIST    = 2'h2;
   localparam logic [1:0]  MODE_PASSWORD   = 2'h1;
   localparam logic [1:0]  MODE_ILLEGAL    = 2'h0;
   localparam logic [3:0]  CMD_VGUARD_WR   = 4'h1;
   localparam logic [3:0]  CMD_PGUARD_PROG = 4'h2;
   localparam logic [3:0]  CMD_PGUARD_ERAS = 4'h3;
   localparam logic [3:0]  CMD_LOCK_CLEAR  = 4'h4;
   localparam logic [3:0]  CMD_PW_PROG     = 4'h5;
   localparam logic [3:0]  CMD_PW_READ     = 4'h6;
   localparam logic [3:0]  CMD_PW_UNLOCK   = 4'h7;
   localparam logic [3:0]  CMD_MODE_PROG   = 4'h8;
   localparam logic [3:0]  CMD_ARRAY_WR    = 4'h9;
   localparam logic [3:0]  CMD_SOFT_RESET  = 4'hA;
   localparam logic [3:0]  CMD_RD_ADDR     = 4'hB;
   localparam logic [63:0] PW_DELIVERED    = 64'hFFFF_FFFF_FFFF_FFFF;
   typedef enum logic [2:0] {
      SPGL_IDLE = 3'b001,
      SPGL_WAIT = 3'b010,
      SPGL_DONE = 3'b100
   } spgl_state_e;
endpackage

// ### verilog/spgl_top.sv
// Purpose: Per-sector guard bits, guard lock and password unlock for a serial flash.
// Assumes: Commands arrive on the link clock as a strobe with opcode, sector and data.
// Notes: Persistent storage is modelled as registers loaded through pins at power-on.
`timescale 1ns/1ps
`default_nettype none
module spgl_top #(
   parameter int unsigned SECTORS  = 16,
   parameter int unsigned WAIT_CYC = spgl_pkg::PW_WAIT_CYC
) (
   // System clock and reset.
   input  wire logic                           sys_clk_in,
   input  wire logic                           nrst_in,
   // Link side command strobe.
   input  wire logic                           link_clk_in,
   input  wire logic                           cmd_valid_in,
   input  wire logic [3:0]                     cmd_op_in,
   input  wire logic [spgl_pkg::SECT_AW-1:0]   cmd_sector_in,
   input  wire logic [spgl_pkg::PW_BITS-1:0]   cmd_data_in,
   // Non-volatile contents restored at power-on; read protect and boot sector sampled live.
   input  wire logic [15:0]                    nv_pguard_in,
   input  wire logic [spgl_pkg::PW_BITS-1:0]   nv_password_in,
   input  wire logic [1:0]                     nv_mode_in,
   input  wire logic                           read_protect_in,
   input  wire logic [spgl_pkg::SECT_AW-1:0]   boot_sector_in,
   // Status and results.
   output logic                                write_in_progress_flag_out,
   output logic                                program_fail_out,
   output logic                                guard_lock_bit_out,
   output logic                                write_allow_out,
   output logic                                pw_read_valid_out,
   output logic [spgl_pkg::PW_BITS-1:0]        pw_read_data_out,
   output logic [spgl_pkg::SECT_AW-1:0]        read_sector_out,
   output logic [1:0]                          protection_mode_reg_out,
   output logic [15:0]                         persistent_sector_guard_out,
   output logic [15:0]                         volatile_sector_guard_out
);
   import spgl_pkg::*;

   // Guard image with every sector open, and the last count of the image load.
   localparam logic [15:0] GUARD_OPEN = 16'hFFFF;
   localparam logic [1:0]  LOAD_LAST  = 2'h2;

   // Link domain: capture command and toggle an event flag.
   logic                 lk_toggle;
   logic [3:0]           lk_op;
   logic [SECT_AW-1:0]   lk_sector;
   logic [PW_BITS-1:0]   lk_data;
   always_ff @(posedge link_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lk_toggle <= 1'b0;
         lk_op     <= 4'h0;
         lk_sector <= '0;
         lk_data   <= '0;
      end else if (cmd_valid_in) begin
         lk_toggle <= ~lk_toggle;
         lk_op     <= cmd_op_in;
         lk_sector <= cmd_sector_in;
         lk_data   <= cmd_data_in;
      end
   end

   // System domain: synchronise the toggle; the payload is stable by then.
   logic sync_a;
   logic sync_b;
   logic sync_c;
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         sync_c <= 1'b0;
      end else begin
         sync_a <= lk_toggle;
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end
   wire cmd_evt = sync_b ^ sync_c;

   // Payload is copied into this domain only once the event has crossed.
   logic               cmd_hit;
   logic [3:0]         sy_op;
   logic [SECT_AW-1:0] sy_sector;
   logic [PW_BITS-1:0] sy_data;
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cmd_hit   <= 1'b0;
         sy_op     <= 4'h0;
         sy_sector <= '0;
         sy_data   <= '0;
      end else begin
         cmd_hit <= cmd_evt;
         if (cmd_evt) begin
            sy_op     <= lk_op;
            sy_sector <= lk_sector;
            sy_data   <= lk_data;
         end
      end
   end

   // Strap inputs pass two flip-flops before use.
   logic [15:0]        nvg_s1;
   logic [15:0]        nvg_s2;
   logic [PW_BITS-1:0] nvp_s1;
   logic [PW_BITS-1:0] nvp_s2;
   logic [1:0]         nvm_s1;
   logic [1:0]         nvm_s2;
   logic [1:0]         rp_s;
   logic [SECT_AW-1:0] bs_s1;
   logic [SECT_AW-1:0] bs_s2;
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         nvg_s1 <= '0;
         nvg_s2 <= '0;
         nvp_s1 <= '0;
         nvp_s2 <= '0;
         nvm_s1 <= MODE_NONE;
         nvm_s2 <= MODE_NONE;
         rp_s   <= 2'h0;
         bs_s1  <= '0;
         bs_s2  <= '0;
      end else begin
         nvg_s1 <= nv_pguard_in;
         nvg_s2 <= nvg_s1;
         nvp_s1 <= nv_password_in;
         nvp_s2 <= nvp_s1;
         nvm_s1 <= nv_mode_in;
         nvm_s2 <= nvm_s1;
         rp_s   <= {rp_s[0], read_protect_in};
         bs_s1  <= boot_sector_in;
         bs_s2  <= bs_s1;
      end
   end

   // Load of non-volatile images happens once after reset release.
   logic [1:0] load_cnt;
   logic       loaded;
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         load_cnt <= 2'h0;
         loaded   <= 1'b0;
      end else if (!loaded) begin
         load_cnt <= load_cnt + 2'h1;
         loaded   <= (load_cnt == LOAD_LAST);
      end
   end
   wire do_load = !loaded && (load_cnt == LOAD_LAST);

   // State registers.
   logic [15:0]        pguard;
   logic [15:0]        vguard;
   logic [PW_BITS-1:0] password;
   logic [1:0]         mode;
   logic               lock;
   logic               busy;
   logic               pfail;
   logic               allow;
   logic               pw_rv;
   logic [PW_BITS-1:0] pw_rd;
   logic [SECT_AW-1:0] rd_sect;
   logic [31:0]        wait_cnt;
   spgl_state_e        state;

   // True for an accepted command carrying the given opcode.
   function automatic logic op_hit(input logic [3:0] got, input logic [3:0] code, input logic take);
      op_hit = take && (got == code);
   endfunction

   // Command decode.
   wire [3:0] op     = sy_op;
   wire       ev     = cmd_hit && loaded;
   wire       pw_md  = (mode == MODE_PASSWORD);
   wire       ev_ok  = ev && !busy;
   wire       sel_v  = vguard[sy_sector];
   wire       sel_p  = pguard[sy_sector];
   wire       is_vwr = op_hit(op, CMD_VGUARD_WR, ev_ok);
   wire       is_pp  = op_hit(op, CMD_PGUARD_PROG, ev_ok);
   wire       is_pe  = op_hit(op, CMD_PGUARD_ERAS, ev_ok);
   wire       is_lc  = op_hit(op, CMD_LOCK_CLEAR, ev_ok);
   wire       is_pwp = op_hit(op, CMD_PW_PROG, ev_ok) && !pw_md;
   wire       is_pwr = op_hit(op, CMD_PW_READ, ev_ok) && !pw_md;
   wire       is_unl = op_hit(op, CMD_PW_UNLOCK, ev_ok) && pw_md;
   wire       is_mp  = op_hit(op, CMD_MODE_PROG, ev_ok) && (mode == MODE_NONE);
   wire       is_aw  = op_hit(op, CMD_ARRAY_WR, ev_ok);
   wire       is_sr  = op_hit(op, CMD_SOFT_RESET, ev_ok);
   wire       is_rd  = op_hit(op, CMD_RD_ADDR, ev_ok);
   wire       pw_hit = (sy_data == password);
   wire       pg_ref = (is_pp || is_pe) && !lock;
   wire       mp_bad = is_mp && (sy_data[1:0] == MODE_ILLEGAL);
   wire       sec_ok = sel_p && sel_v;
   wire       wait_end = (state == SPGL_WAIT) && (wait_cnt == WAIT_CYC - 32'd1);

   // Volatile guards: writable whenever not busy, regardless of lock; reset to unprotected.
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         vguard <= GUARD_OPEN;
      end else if (is_sr) begin
         vguard <= GUARD_OPEN;
      end else if (is_vwr) begin
         vguard[sy_sector] <= sy_data[0];
      end
   end

   // Persistent guards: restored from storage, changed only while unlocked.
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pguard <= GUARD_OPEN;
      end else if (do_load) begin
         pguard <= nvg_s2;
      end else if (is_pp && lock) begin
         pguard[sy_sector] <= 1'b0;
      end else if (is_pe && lock) begin
         pguard <= GUARD_OPEN;
      end
   end

   // Password store and mode bits.
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         password <= PW_DELIVERED;
         mode     <= MODE_NONE;
      end else if (do_load) begin
         password <= nvp_s2;
         mode     <= nvm_s2;
      end else begin
         if (is_pwp) begin
            password <= password & sy_data;
         end
         if (is_mp && !mp_bad) begin
            mode <= mode & sy_data[1:0];
         end
      end
   end

   // Guard lock: set or cleared at reset by mode, soft reset leaves it.
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lock <= 1'b0;
      end else if (do_load) begin
         lock <= (nvm_s2 != MODE_PASSWORD);
      end else if (is_lc) begin
         lock <= 1'b0;
      end else if (is_unl && pw_hit) begin
         lock <= 1'b1;
      end
   end

   // Unlock sequencer and busy flag.
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state    <= SPGL_IDLE;
         wait_cnt <= 32'd0;
         busy     <= 1'b0;
      end else begin
         case (state)
            SPGL_IDLE: begin
               if (is_unl && !pw_hit) begin
                  state    <= SPGL_WAIT;
                  wait_cnt <= 32'd0;
                  busy     <= 1'b1;
               end else if (is_unl) begin
                  state <= SPGL_DONE;
                  busy  <= 1'b1;
               end
            end
            SPGL_WAIT: begin
               wait_cnt <= wait_cnt + 32'd1;
               if (wait_end) begin
                  state <= SPGL_DONE;
               end
            end
            SPGL_DONE: begin
               state <= SPGL_IDLE;
               busy  <= 1'b0;
            end
            default: begin
               state <= SPGL_IDLE;
               busy  <= 1'b0;
            end
         endcase
      end
   end

   // Failure flag, write permission, password read and read address.
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pfail   <= 1'b0;
         allow   <= 1'b0;
         pw_rv   <= 1'b0;
         pw_rd   <= '0;
         rd_sect <= '0;
      end else begin
         pw_rv <= is_pwr;
         if (is_unl && !pw_hit) begin
            pfail <= 1'b1;
         end else if (pg_ref || mp_bad || (is_aw && !sec_ok)) begin
            pfail <= 1'b1;
         end else if (ev_ok) begin
            pfail <= 1'b0;
         end
         if (is_aw) begin
            allow <= sec_ok;
         end
         if (is_pwr) begin
            pw_rd <= password;
         end
         if (is_rd) begin
            rd_sect <= rp_s[1] ? bs_s2 : sy_sector;
         end
      end
   end

   assign write_in_progress_flag_out  = busy;
   assign program_fail_out            = pfail;
   assign guard_lock_bit_out          = lock;
   assign write_allow_out             = allow;
   assign pw_read_valid_out           = pw_rv;
   assign pw_read_data_out            = pw_rd;
   assign read_sector_out             = rd_sect;
   assign protection_mode_reg_out     = mode;
   assign persistent_sector_guard_out = pguard;
   assign volatile_sector_guard_out   = vguard;
endmodule
`default_nettype wire

// ### dv/spgl_checker.sv
// Purpose: Concurrent checks on the ports of the sector guard and password lock block.
// Assumes: One system clock domain; reset is asynchronous and active low.
// Notes: Bound to spgl_top after the module.
`timescale 1ns/1ps
`default_nettype none
module spgl_checker #(
   parameter int unsigned WAIT_CYC = 20
) (
   // Clock, reset and level inputs.
   input wire logic                          sys_clk_in,
   input wire logic                          nrst_in,
   input wire logic                          read_protect_in,
   input wire logic [spgl_pkg::SECT_AW-1:0]  boot_sector_in,
   // Watched outputs.
   input wire logic                          write_in_progress_flag_out,
   input wire logic                          program_fail_out,
   input wire logic                          guard_lock_bit_out,
   input wire logic                          pw_read_valid_out,
   input wire logic [spgl_pkg::SECT_AW-1:0]  read_sector_out,
   input wire logic [1:0]                    protection_mode_reg_out,
   input wire logic [15:0]                   persistent_sector_guard_out
);
   import spgl_pkg::*;
   wire logic        busy = write_in_progress_flag_out;
   wire logic        lock = guard_lock_bit_out;
   wire logic [1:0]  md   = protection_mode_reg_out;
   logic [3:0]       up;
   logic [15:0]      blen;
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         up   <= 4'h0;
         blen <= 16'h0000;
      end else begin
         up   <= (up == 4'hF) ? up : up + 4'h1;
         blen <= busy ? blen + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   sequence s_unlock_fail;
      $rose(busy) && !lock;
   endsequence
   property p_lock_rise; $rose(lock) |-> (up < 4'hA) || (md == MODE_PASSWORD && busy); endproperty
   a_lock_rise: assert property (p_lock_rise) else $error("lock rose late");
   property p_pg_lock; up >= 4'hA && !$stable(persistent_sector_guard_out) |-> $past(lock); endproperty
   a_pg_lock: assert property (p_pg_lock) else $error("guard changed while locked");
   property p_mode_frozen; up >= 4'hA && $past(md) != MODE_NONE |-> $stable(md); endproperty
   a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed");
   property p_pw_hidden; pw_read_valid_out |-> md != MODE_PASSWORD; endproperty
   a_pw_hidden: assert property (p_pw_hidden) else $error("password read in password mode");
   property p_fail_flag; s_unlock_fail |-> program_fail_out ##1 busy [*8]; endproperty
   a_fail_flag: assert property (p_fail_flag) else $error("mismatch flags wrong");
   property p_busy_len; $fell(busy) |-> blen <= 16'h0002 || (blen >= WAIT_CYC && blen <= WAIT_CYC + 2); endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   property p_lock_hold; busy && $past(busy) |-> $stable(lock); endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock moved while busy");
   property p_boot; read_protect_in && $changed(read_sector_out) |-> read_sector_out == boot_sector_in; endproperty
   a_boot: assert property (p_boot) else $error("read address not forced");
endmodule
bind spgl_top spgl_checker #(.WAIT_CYC(WAIT_CYC)) spgl_checker_i (.sys_clk_in, .nrst_in, .read_protect_in,
   .boot_sector_in, .write_in_progress_flag_out, .program_fail_out, .guard_lock_bit_out, .pw_read_valid_out,
   .read_sector_out, .protection_mode_reg_out, .persistent_sector_guard_out);
`default_nettype wire

// ### dv/spgl_host_model.sv
// Purpose: Host controller model issuing protection commands on the link clock.
// Assumes: One command per strobe; spacing is left to the caller.
// Notes: Released payload lines show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module spgl_host_model (
   // Link clock and command strobe.
   input  wire logic                         link_clk_in,
   output var logic                          cmd_valid_out,
   output var logic [3:0]                    cmd_op_out,
   output var logic [spgl_pkg::SECT_AW-1:0]  cmd_sector_out,
   output var logic [spgl_pkg::PW_BITS-1:0]  cmd_data_out
);
   import spgl_pkg::*;
   initial begin
      cmd_valid_out  = 1'h0;
      cmd_op_out     = 4'h0;
      cmd_sector_out = 4'h0;
      cmd_data_out   = 64'h0;
   end
   task automatic send(input logic [3:0] op, input logic [3:0] sec, input logic [63:0] data);
      @(posedge link_clk_in);
      #1;
      cmd_op_out     = op;
      cmd_sector_out = sec;
      cmd_data_out   = data;
      cmd_valid_out  = 1'h1;
      @(posedge link_clk_in);
      #1;
      cmd_valid_out  = 1'h0;
      cmd_op_out     = ~op;
      cmd_sector_out = ~sec;
      cmd_data_out   = ~data;
   endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Purpose: Self-checking bench for the sector guard and password lock block.
// Assumes: Rate-limit wait shortened to 20 cycles; commands through cmd spaced 10 system cycles, the last unlock sends as soon as busy falls.
// Notes: Stored images change only while reset is held.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import spgl_pkg::*;
   localparam int unsigned W   = 20;
   localparam logic [63:0] PWV = 64'h5A5A_0F0F_3C3C_9669;
   localparam logic [63:0] PWF = 64'h5A5A_0F0F_3C3C_9668;
   logic        sys_clk  = 1'h0;
   logic        link_clk = 1'h0;
   logic        nrst     = 1'h0;
   logic        rp       = 1'h0;
   int          n_pwv    = 0;
   logic [3:0]  boot     = 4'h3;
   logic [15:0] nv_pg    = 16'hFFF0;
   logic [63:0] nv_pw    = PW_DELIVERED;
   logic [1:0]  nv_md    = MODE_NONE;
   logic        cv, busy, fail, lock, allow, pwv;
   logic [3:0]  cop, csec, rsec;
   logic [63:0] cdat, pwd;
   logic [1:0]  md;
   logic [15:0] pg, vg;
   int          n_fail = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          n;
   always #12.5 sys_clk = ~sys_clk;
   always #6 link_clk = ~link_clk;
   spgl_top #(.WAIT_CYC(W)) spgl_top_i (
      .sys_clk_in(sys_clk), .nrst_in(nrst), .link_clk_in(link_clk), .cmd_valid_in(cv), .cmd_op_in(cop),
      .cmd_sector_in(csec), .cmd_data_in(cdat), .nv_pguard_in(nv_pg), .nv_password_in(nv_pw), .nv_mode_in(nv_md),
      .read_protect_in(rp), .boot_sector_in(boot), .write_in_progress_flag_out(busy), .program_fail_out(fail),
      .guard_lock_bit_out(lock), .write_allow_out(allow), .pw_read_valid_out(pwv), .pw_read_data_out(pwd),
      .read_sector_out(rsec), .protection_mode_reg_out(md), .persistent_sector_guard_out(pg),
      .volatile_sector_guard_out(vg));
   spgl_host_model spgl_host_model_i (.link_clk_in(link_clk), .cmd_valid_out(cv), .cmd_op_out(cop),
      .cmd_sector_out(csec), .cmd_data_out(cdat));
   task automatic report_and_stop();
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (pwv === 1'h1) n_pwv++;
      if (cyc == 5000) begin
         n_fail++;
         report_and_stop();
      end
   end
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cmd(input logic [3:0] o, input logic [3:0] s, input logic [63:0] d);
      spgl_host_model_i.send(o, s, d);
      repeat (10) @(posedge sys_clk);
      #1;
   endtask
   task automatic boot_up(input logic [15:0] p, input logic [63:0] w, input logic [1:0] m);
      @(posedge sys_clk);
      #1;
      nrst  = 1'h0;
      nv_pg = p;
      nv_pw = w;
      nv_md = m;
      repeat (5) @(posedge sys_clk);
      #1;
      nrst = 1'h1;
      repeat (8) @(posedge sys_clk);
      #1;
   endtask
   task automatic busy_len(output int k);
      k = 0;
      for (int i = 0; i < 10 && busy !== 1'h1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      while (busy === 1'h1 && k < 100) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
   endtask
   initial begin
      boot_up(16'hFFF0, PW_DELIVERED, MODE_NONE);
      chk("lock", lock, 1'h1);
      chk("vg", vg, 16'hFFFF);
      chk("pg", pg, 16'hFFF0);
      cmd(CMD_ARRAY_WR, 4'h0, 64'h0);
      chk("allow", allow, 1'h0);
      cmd(CMD_ARRAY_WR, 4'h5, 64'h0);
      chk("allow", allow, 1'h1);
      cmd(CMD_VGUARD_WR, 4'h5, 64'h0);
      chk("vg", vg, 16'hFFDF);
      cmd(CMD_ARRAY_WR, 4'h5, 64'h0);
      chk("allow", allow, 1'h0);
      cmd(CMD_VGUARD_WR, 4'h5, 64'h1);
      cmd(CMD_PGUARD_PROG, 4'h6, 64'h0);
      chk("pg", pg, 16'hFFB0);
      cmd(CMD_PGUARD_ERAS, 4'h0, 64'h0);
      chk("pg", pg, 16'hFFFF);
      cmd(CMD_PGUARD_PROG, 4'h7, 64'h0);
      cmd(CMD_SOFT_RESET, 4'h0, 64'h0);
      chk("lock", lock, 1'h1);
      chk("pg", pg, 16'hFF7F);
      cmd(CMD_LOCK_CLEAR, 4'h0, 64'h0);
      chk("lock", lock, 1'h0);
      cmd(CMD_PGUARD_PROG, 4'h8, 64'h0);
      chk("fail", fail, 1'h1);
      cmd(CMD_PGUARD_ERAS, 4'h0, 64'h0);
      chk("pg", pg, 16'hFF7F);
      cmd(CMD_VGUARD_WR, 4'h2, 64'h0);
      chk("vg", vg, 16'hFFFB);
      cmd(CMD_PW_UNLOCK, 4'h0, PW_DELIVERED);
      chk("lock", lock, 1'h0);
      cmd(CMD_SOFT_RESET, 4'h0, 64'h0);
      chk("vg", vg, 16'hFFFF);
      chk("lock", lock, 1'h0);
      cmd(CMD_PW_READ, 4'h0, 64'h0);
      chk("pwv", n_pwv, 1'h1);
      chk("pwd", pwd, PW_DELIVERED);
      cmd(CMD_PW_PROG, 4'h0, PWV);
      cmd(CMD_PW_PROG, 4'h0, 64'hFFFF_FFFF_FFFF_FFFE);
      chk("fail", fail, 1'h0);
      cmd(CMD_PW_READ, 4'h0, 64'h0);
      chk("pwd", pwd, PWF);
      chk("pwv", n_pwv, 2'h2);
      rp = 1'h1;
      cmd(CMD_RD_ADDR, 4'h9, 64'h0);
      chk("rsec", rsec, 4'h3);
      rp = 1'h0;
      cmd(CMD_RD_ADDR, 4'h9, 64'h0);
      chk("rsec", rsec, 4'h9);
      cmd(CMD_MODE_PROG, 4'h0, 64'h0);
      chk("fail", fail, 1'h1);
      cmd(CMD_MODE_PROG, 4'h0, 64'h2);
      chk("md", md, MODE_PERSIST);
      cmd(CMD_MODE_PROG, 4'h0, 64'h1);
      chk("md", md, MODE_PERSIST);
      boot_up(16'hFFFF, PWF, MODE_PASSWORD);
      chk("lock", lock, 1'h0);
      n = n_pwv;
      cmd(CMD_PW_READ, 4'h0, 64'h0);
      chk("pwv", n_pwv, n);
      chk("pwd", pwd, 64'h0);
      cmd(CMD_PW_UNLOCK, 4'h0, PWF ^ 64'h8000_0000_0000_0000);
      chk("busy", busy, 1'h1);
      chk("fail", fail, 1'h1);
      spgl_host_model_i.send(CMD_PW_UNLOCK, 4'h0, PWF);
      busy_len(n);
      chk("lock", lock, 1'h0);
      spgl_host_model_i.send(CMD_PW_UNLOCK, 4'h0, PWF ^ 64'h1);
      busy_len(n);
      chk("wait", n >= W && n <= W + 2, 1'h1);
      spgl_host_model_i.send(CMD_PW_UNLOCK, 4'h0, PWF);
      busy_len(n);
      chk("fast", n >= 1 && n <= 2, 1'h1);
      chk("lock", lock, 1'h1);
      repeat (4) @(posedge sys_clk);
      cmd(CMD_PGUARD_PROG, 4'h1, 64'h0);
      chk("pg", pg, 16'hFFFD);
      report_and_stop();
   end
endmodule
`default_nettype wire
